// [sdo_pkg.sv]
/*
 * Shared constants and types of the status digital output mapper: register map,
 * field positions, reset values, state selector codes and the register state record.
 * Assumes a 32-bit classic Wishbone bus with byte addresses on the low 8 bits.
 */
`default_nettype none
package sdo_pkg;
	// ==========================================================================
	// sizes
	localparam int SDO_NUM_OUT = 8;
	localparam int SDO_SEL_W = 5;
	localparam int SDO_RD_W = 16;
	localparam int SDO_NUM_FAULT = 10;
	// ==========================================================================
	// register byte offsets
	localparam logic [7:0] SDO_ADR_CTRL = 8'h00;
	localparam logic [7:0] SDO_ADR_IDLE = 8'h04;
	localparam logic [7:0] SDO_ADR_POINT = 8'h08;
	localparam logic [7:0] SDO_ADR_SEQ = 8'h0C;
	localparam logic [7:0] SDO_ADR_ALARM = 8'h10;
	localparam logic [7:0] SDO_ADR_POL = 8'h14;
	localparam logic [7:0] SDO_ADR_SEL_LO = 8'h18;
	localparam logic [7:0] SDO_ADR_SEL_HI = 8'h1C;
	localparam logic [7:0] SDO_ADR_STATE = 8'h20;
	localparam logic [7:0] SDO_ADR_OUT = 8'h24;
	localparam logic [7:0] SDO_ADR_ISTS = 8'h28;
	localparam logic [7:0] SDO_ADR_IMASK = 8'h2C;
	localparam logic [7:0] SDO_ADR_RSV = 8'h30;
	localparam logic [7:0] SDO_ADR_RANGE = 8'h34;
	// ==========================================================================
	// field positions
	localparam int SDO_CTRL_OVR_EN = 0;
	localparam int SDO_IRQ_SYSF = 0;
	localparam int SDO_IRQ_OVR_IN = 1;
	localparam int SDO_IRQ_OVR_OUT = 2;
	localparam int SDO_SEL_FIELD = 8;
	// fault flag input bit order
	localparam int SDO_F_SUPPLY = 0;
	localparam int SDO_F_REFV = 1;
	localparam int SDO_F_CONV = 2;
	localparam int SDO_F_LAMP = 3;
	localparam int SDO_F_FLOW = 4;
	localparam int SDO_F_FLOWHT = 5;
	localparam int SDO_F_LAMPHT = 6;
	localparam int SDO_F_CHASSIS = 7;
	localparam int SDO_F_STORAGE = 8;
	localparam int SDO_F_DILUENT = 9;
	// ==========================================================================
	// state selector codes
	localparam logic [4:0] SDO_ST_DISABLED = 5'h00;
	localparam logic [4:0] SDO_ST_SUPPLY = 5'h01;
	localparam logic [4:0] SDO_ST_REFV = 5'h02;
	localparam logic [4:0] SDO_ST_CONV = 5'h03;
	localparam logic [4:0] SDO_ST_LAMP = 5'h04;
	localparam logic [4:0] SDO_ST_FLOW = 5'h05;
	localparam logic [4:0] SDO_ST_FLOWHT = 5'h06;
	localparam logic [4:0] SDO_ST_LAMPHT = 5'h07;
	localparam logic [4:0] SDO_ST_CHASSIS = 5'h08;
	localparam logic [4:0] SDO_ST_STORAGE = 5'h09;
	localparam logic [4:0] SDO_ST_BACKGND = 5'h0A;
	localparam logic [4:0] SDO_ST_SPAN = 5'h0B;
	localparam logic [4:0] SDO_ST_ZERO = 5'h0C;
	localparam logic [4:0] SDO_ST_SYSF = 5'h0D;
	localparam logic [4:0] SDO_ST_DILUENT = 5'h0E;
	localparam logic [4:0] SDO_ST_MAINT = 5'h0F;
	localparam logic [4:0] SDO_ST_OVR = 5'h10;
	// ==========================================================================
	// reset values and over-range thresholds in percent of the standard range
	localparam logic [7:0] SDO_RST_MASK = 8'h00;
	localparam logic [15:0] SDO_RST_RANGE = 16'hFFFF;
	localparam logic [6:0] SDO_OVR_ENTER_PCT = 7'h5A;
	localparam logic [6:0] SDO_OVR_EXIT_PCT = 7'h50;
	localparam logic [6:0] SDO_PCT_FULL = 7'h64;
	// ==========================================================================
	// register state of the mapper
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic ovr_en;
		logic [7:0] idle;
		logic [7:0] point;
		logic [7:0] seq;
		logic [7:0] alarm;
		logic [7:0] pol;
		logic [7:0][4:0] sel;
		logic [15:0] range;
		logic [2:0] ists;
		logic [2:0] imask;
		logic sysf_d;
		logic ovr_d;
		logic [7:0] dout;
		logic irq;
	} sdo_regs_t;
	typedef enum logic {SDO_SCALE_STD, SDO_SCALE_OVR} sdo_scale_t;
endpackage
`default_nettype wire

// [sdo_range_if.sv]
/*
 * Carrier between the mapper and its over-range tracker.
 * Assumes both ends run on the one system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface sdo_range_if;
	logic [15:0] reading;
	logic [15:0] range;
	logic enable;
	logic over;
	modport ctrl (output reading, output range, output enable, input over);
	modport trk (input reading, input range, input enable, output over);
endinterface
`default_nettype wire

// [sdo_range_track.sv]
/*
 * Over-range tracker for analog channel one: hysteresis between the standard
 * and the alternate scale. Assumes reading and range are synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sdo_range_track
	import sdo_pkg::*;
(
	input wire logic core_clk_in, // system clock
	input wire logic rst_in, // async reset, active high
	sdo_range_if.trk rif // reading, range, enable, over
);
	// ==========================================================================
	// scaled comparison, reading*100 against range*pct
	typedef struct packed {
		sdo_scale_t scale;
	} sdo_trk_t;
	sdo_trk_t r, n;
	logic [23:0] rd_x100;
	logic [23:0] rng_enter;
	logic [23:0] rng_exit;

	// products fit 24 bits: 16-bit value times 7-bit percent
	assign rd_x100 = 24'(rif.reading) * 24'(SDO_PCT_FULL);
	assign rng_enter = 24'(rif.range) * 24'(SDO_OVR_ENTER_PCT);
	assign rng_exit = 24'(rif.range) * 24'(SDO_OVR_EXIT_PCT);
	assign rif.over = (r.scale == SDO_SCALE_OVR);

	// enter at 90 percent, fall back at 80 percent; disabling drops the alternate scale
	always_comb begin
		n = r;
		if (!rif.enable) begin
			n.scale = SDO_SCALE_STD;
		end else begin
			unique case (r.scale)
				SDO_SCALE_STD: if (rd_x100 >= rng_enter) n.scale = SDO_SCALE_OVR;
				SDO_SCALE_OVR: if (rd_x100 <= rng_exit) n.scale = SDO_SCALE_STD;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			r.scale <= SDO_SCALE_STD;
		end else begin
			r <= n;
		end
	end

	// ==========================================================================
	// checks
	a_ovr_enter: assert property (@(posedge core_clk_in) disable iff (rst_in)
		rif.enable && rd_x100 >= rng_enter |=> rif.over) else $error("over-range not entered");
	a_ovr_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
		rif.over && rif.enable && rd_x100 > rng_exit |=> rif.over) else $error("over-range left early");
endmodule
`default_nettype wire

// [sdo_mapper.sv]
/*
 * Status digital output mapper: eight discrete status lines built from an idle
 * pattern, point, sequence and alarm masks, or from one instrument state each,
 * with per-line polarity; classic Wishbone register slave and one level interrupt.
 * Assumes all inputs are synchronous to core_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module sdo_mapper
	import sdo_pkg::*;
(
	input wire logic core_clk_in, // 100 MHz system clock
	input wire logic rst_in, // async reset, active high
	input wire logic wb_cyc_in, // wishbone cycle
	input wire logic wb_stb_in, // wishbone strobe
	input wire logic wb_we_in, // wishbone write enable
	input wire logic [7:0] wb_adr_in, // byte address
	input wire logic [3:0] wb_sel_in, // byte lanes
	input wire logic [31:0] wb_dat_in, // write data
	output logic [31:0] wb_dat_out, // read data
	output logic wb_ack_out, // transfer acknowledge
	input wire logic running_in, // point or sequence running
	input wire logic [sdo_pkg::SDO_NUM_FAULT-1:0] fault_flags_in, // individual faults
	input wire logic background_in, // background in progress
	input wire logic span_in, // span check in progress
	input wire logic zero_in, // zero check in progress
	input wire logic maintenance_in, // maintenance mode
	input wire logic [sdo_pkg::SDO_RD_W-1:0] analog_reading_in, // analog channel one reading
	output logic [sdo_pkg::SDO_NUM_OUT-1:0] dout_out, // discrete status lines
	output logic irq_out // level interrupt
);
	// ==========================================================================
	// register map, byte offsets on the low address byte:
	// 00 control, bit 0 enables the alternate scale
	// 04 idle pattern, 08 point mask, 0C sequence mask, 10 alarm-assigned lines
	// 14 polarity, a one makes the line active low
	// 18 selectors of lines 0-3, 1C of lines 4-7, five bits at the foot of each byte
	// 20 state vector, 24 lines as driven, both read only
	// 28 interrupt status, write one to clear; 2C interrupt mask
	// 30 lines taken by alarms or selectors, read only; 34 standard range
	// unmapped offsets answer like any other, so software never hangs on a typo
	// ==========================================================================
	// helpers
	sdo_regs_t r, n;
	logic [31:0] sv;
	logic [7:0] assigned;
	logic ovr_state;
	logic sysf;
	logic acc;
	logic wr;
	sdo_range_if rif ();

	// byte-lane merge of a write into a register word
	function automatic logic [31:0] sdo_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (d & m);
	endfunction

	// state vector indexed by selector code; code zero and unused codes stay low
	function automatic logic [31:0] sdo_state_vec(input logic [9:0] f, input logic bg, input logic sp,
		input logic zr, input logic mt, input logic ov);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[SDO_ST_SUPPLY] = f[SDO_F_SUPPLY];
		v[SDO_ST_REFV] = f[SDO_F_REFV];
		v[SDO_ST_CONV] = f[SDO_F_CONV];
		v[SDO_ST_LAMP] = f[SDO_F_LAMP];
		v[SDO_ST_FLOW] = f[SDO_F_FLOW];
		v[SDO_ST_FLOWHT] = f[SDO_F_FLOWHT];
		v[SDO_ST_LAMPHT] = f[SDO_F_LAMPHT];
		v[SDO_ST_CHASSIS] = f[SDO_F_CHASSIS];
		v[SDO_ST_STORAGE] = f[SDO_F_STORAGE];
		v[SDO_ST_DILUENT] = f[SDO_F_DILUENT];
		v[SDO_ST_BACKGND] = bg;
		v[SDO_ST_SPAN] = sp;
		v[SDO_ST_ZERO] = zr;
		v[SDO_ST_SYSF] = |f;
		v[SDO_ST_MAINT] = mt;
		v[SDO_ST_OVR] = ov;
		return v;
	endfunction

	// ==========================================================================
	// over-range tracker for analog channel one
	assign rif.reading = analog_reading_in;
	assign rif.range = r.range;
	assign rif.enable = r.ovr_en;
	assign ovr_state = rif.over;

	sdo_range_track u_trk (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.rif(rif.trk)
	);

	// ==========================================================================
	// combinational decode
	assign sysf = |fault_flags_in;
	assign sv = sdo_state_vec(fault_flags_in, background_in, span_in, zero_in, maintenance_in, ovr_state);
	assign acc = wb_cyc_in & wb_stb_in & ~r.ack;
	assign wr = acc & wb_we_in;

	// outputs with a non-disabled selector belong to their state alone
	always_comb begin
		for (int i = 0; i < SDO_NUM_OUT; i++) begin
			assigned[i] = (r.sel[i] != SDO_ST_DISABLED);
		end
	end

	// next state: bus access, events, output mapping
	always_comb begin
		logic [31:0] cur;
		logic [2:0] ev;
		logic [2:0] clr;
		logic act;
		logic [31:0] mrg;
		cur = 32'h0000_0000;
		mrg = 32'h0000_0000;
		ev = 3'h0;
		clr = 3'h0;
		act = 1'b0;
		n = r;
		// one wait state: ack rises the cycle after the request, then drops
		n.ack = acc;
		n.rdat = 32'h0000_0000;
		unique case (wb_adr_in)
			SDO_ADR_CTRL: cur = {31'h0, r.ovr_en};
			SDO_ADR_IDLE: cur = {24'h0, r.idle};
			SDO_ADR_POINT: cur = {24'h0, r.point};
			SDO_ADR_SEQ: cur = {24'h0, r.seq};
			SDO_ADR_ALARM: cur = {24'h0, r.alarm};
			SDO_ADR_POL: cur = {24'h0, r.pol};
			SDO_ADR_SEL_LO: cur = {3'h0, r.sel[3], 3'h0, r.sel[2], 3'h0, r.sel[1], 3'h0, r.sel[0]};
			SDO_ADR_SEL_HI: cur = {3'h0, r.sel[7], 3'h0, r.sel[6], 3'h0, r.sel[5], 3'h0, r.sel[4]};
			SDO_ADR_STATE: cur = sv;
			SDO_ADR_OUT: cur = {24'h0, r.dout};
			SDO_ADR_ISTS: cur = {29'h0, r.ists};
			SDO_ADR_IMASK: cur = {29'h0, r.imask};
			SDO_ADR_RSV: cur = {24'h0, r.alarm | assigned};
			SDO_ADR_RANGE: cur = {16'h0, r.range};
			default: cur = 32'h0000_0000; // unmapped: reads zero, writes dropped
		endcase
		if (acc && !wb_we_in) begin
			n.rdat = cur;
		end
		// merge once into a variable; a call result cannot be sliced in place
		mrg = sdo_merge(cur, wb_dat_in, wb_sel_in);
		if (wr) begin
			unique case (wb_adr_in)
				SDO_ADR_CTRL: n.ovr_en = mrg[SDO_CTRL_OVR_EN];
				SDO_ADR_IDLE: n.idle = mrg[7:0];
				SDO_ADR_POINT: n.point = mrg[7:0];
				SDO_ADR_SEQ: n.seq = mrg[7:0];
				SDO_ADR_ALARM: n.alarm = mrg[7:0];
				SDO_ADR_POL: n.pol = mrg[7:0];
				SDO_ADR_SEL_LO: begin
					for (int i = 0; i < 4; i++) begin
						n.sel[i] = mrg[i*SDO_SEL_FIELD +: SDO_SEL_W];
					end
				end
				SDO_ADR_SEL_HI: begin
					for (int i = 0; i < 4; i++) begin
						n.sel[i+4] = mrg[i*SDO_SEL_FIELD +: SDO_SEL_W];
					end
				end
				SDO_ADR_ISTS: clr = wb_sel_in[0] ? wb_dat_in[2:0] : 3'h0;
				SDO_ADR_IMASK: n.imask = mrg[2:0];
				SDO_ADR_RANGE: n.range = mrg[15:0];
				default: n.imask = r.imask;
			endcase
		end
		// events; a set in the clearing cycle wins over the clear
		n.sysf_d = sysf;
		n.ovr_d = ovr_state;
		ev[SDO_IRQ_SYSF] = sysf & ~r.sysf_d;
		ev[SDO_IRQ_OVR_IN] = ovr_state & ~r.ovr_d;
		ev[SDO_IRQ_OVR_OUT] = ~ovr_state & r.ovr_d;
		n.ists = (r.ists & ~clr) | ev;
		n.irq = |(n.ists & n.imask);
		// output mapping, then polarity
		for (int i = 0; i < SDO_NUM_OUT; i++) begin
			if (assigned[i]) begin
				act = sv[r.sel[i]];
			end else if (running_in) begin
				act = r.idle[i] | r.point[i] | r.seq[i] | r.alarm[i];
			end else begin
				act = r.idle[i];
			end
			n.dout[i] = act ^ r.pol[i];
		end
	end

	// single register stage for all state; reset leaves every line inactive
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			r.ack <= 1'b0;
			r.rdat <= 32'h0000_0000;
			r.ovr_en <= 1'b0;
			r.idle <= SDO_RST_MASK;
			r.point <= SDO_RST_MASK;
			r.seq <= SDO_RST_MASK;
			r.alarm <= SDO_RST_MASK;
			r.pol <= SDO_RST_MASK;
			r.sel <= '0;
			r.range <= SDO_RST_RANGE;
			r.ists <= 3'h0;
			r.imask <= 3'h0;
			r.sysf_d <= 1'b0;
			r.ovr_d <= 1'b0;
			r.dout <= SDO_RST_MASK;
			r.irq <= 1'b0;
		end else begin
			r <= n;
		end
	end

	// every output straight from a flip-flop
	assign wb_ack_out = r.ack;
	assign wb_dat_out = r.rdat;
	assign dout_out = r.dout;
	assign irq_out = r.irq;

	// ==========================================================================
	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	a_idle_pattern: assert property (!running_in && r.sel[0] == SDO_ST_DISABLED && !r.pol[0]
		|=> dout_out[0] == $past(r.idle[0])) else $error("idle pattern not driven");
	a_run_or_mask: assert property (running_in && !assigned[1] && !r.pol[1] && (r.point[1] || r.alarm[1])
		|=> dout_out[1]) else $error("running OR combine lost a one");
	sequence s_zero_sel;
		r.sel[2] == SDO_ST_ZERO && !r.pol[2];
	endsequence
	sequence s_zero_done;
		zero_in ##1 !zero_in;
	endsequence
	a_state_follow: assert property (s_zero_sel ##0 s_zero_done |=> !dout_out[2] && $past(dout_out[2]))
		else $error("assigned output did not track its state");
	a_mask_excluded: assert property (assigned[3] && !sv[r.sel[3]] && !r.pol[3] && (r.point[3] || r.seq[3])
		|=> !dout_out[3]) else $error("mask reached an assigned output");
	a_polarity_low: assert property (r.sel[4] == SDO_ST_SPAN && r.pol[4] && span_in
		|=> !dout_out[4]) else $error("active low line not driven low");
	a_disabled_quiet: assert property (!assigned[5] && !running_in && !r.idle[5] && !r.pol[5]
		|=> !dout_out[5]) else $error("disabled output asserted");
	a_sysfault_line: assert property (r.sel[6] == SDO_ST_SYSF && !r.pol[6] && |fault_flags_in
		|=> dout_out[6]) else $error("system fault not shown");
	a_ovr_line: assert property (r.sel[7] == SDO_ST_OVR && !r.pol[7]
		|=> dout_out[7] == $past(ovr_state)) else $error("over-range state not shown");
	// an unmasked system fault edge reaches the pin one edge after it is seen
	a_irq_level: assert property (sysf && !r.sysf_d && r.imask[SDO_IRQ_SYSF] && !wr |=> irq_out)
		else $error("unmasked event gave no interrupt");
	a_ack_once: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held two cycles");
	// checked one edge into reset, since the very first edge may meet flops not yet cleared
	a_reset_quiet: assert property (disable iff (1'b0) rst_in |=> dout_out == SDO_RST_MASK && !irq_out)
		else $error("outputs active in reset");

	// ==========================================================================
	// bus timing: always one wait state, and read data only beside ack
	a_ack_wait: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack not given after one wait state");
	a_rdat_quiet: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
		else $error("read data shown without ack");
	// reserved view: a read of it shows alarm bits and assigned lines as taken
	sequence s_rsv_read;
		wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out && wb_adr_in == SDO_ADR_RSV;
	endsequence
	a_rsv_view: assert property (s_rsv_read |=> wb_dat_out[7:0] == $past(r.alarm | assigned))
		else $error("reserved view wrong");

	// ==========================================================================
	// status bits: sticky until a write clears them, and set on over-range edges
	a_status_sticky: assert property (r.ists[SDO_IRQ_SYSF] && !wr |=> r.ists[SDO_IRQ_SYSF])
		else $error("status bit lost without a clear");
	sequence s_ovr_rise;
		!ovr_state ##1 ovr_state;
	endsequence
	sequence s_ovr_fall;
		ovr_state ##1 !ovr_state;
	endsequence
	a_ovr_entry_flag: assert property (s_ovr_rise |=> r.ists[SDO_IRQ_OVR_IN])
		else $error("over-range entry not recorded");
	a_ovr_exit_flag: assert property (s_ovr_fall |=> r.ists[SDO_IRQ_OVR_OUT])
		else $error("over-range exit not recorded");

	// ==========================================================================
	// per-line checks, repeated for every line so that no selector position goes unwatched
	for (genvar g = 0; g < SDO_NUM_OUT; g++) begin : g_line
		// idle: an unassigned line shows its idle bit after polarity
		a_idle_line: assert property (@(posedge core_clk_in) disable iff (rst_in)
			!running_in && !assigned[g]
			|=> dout_out[g] == ($past(r.idle[g]) ^ $past(r.pol[g])))
			else $error("idle bit not on its line");
		// running: any contributing one makes the line active
		a_run_line: assert property (@(posedge core_clk_in) disable iff (rst_in)
			running_in && !assigned[g] && (r.idle[g] || r.point[g] || r.seq[g] || r.alarm[g])
			|=> dout_out[g] == !$past(r.pol[g]))
			else $error("contributing one lost");
		// running: with no contribution at all the line stays inactive
		a_run_none: assert property (@(posedge core_clk_in) disable iff (rst_in)
			running_in && !assigned[g] && !(r.idle[g] || r.point[g] || r.seq[g] || r.alarm[g])
			|=> dout_out[g] == $past(r.pol[g]))
			else $error("line active with no contribution");
		// operating phases drive their line while they last
		a_phase_line: assert property (@(posedge core_clk_in) disable iff (rst_in)
			!r.pol[g] && ((r.sel[g] == SDO_ST_BACKGND && background_in)
			|| (r.sel[g] == SDO_ST_SPAN && span_in) || (r.sel[g] == SDO_ST_ZERO && zero_in))
			|=> dout_out[g])
			else $error("phase line not active");
		// maintenance line follows the operator's mode
		a_maint_line: assert property (@(posedge core_clk_in) disable iff (rst_in)
			r.sel[g] == SDO_ST_MAINT && !r.pol[g]
			|=> dout_out[g] == $past(maintenance_in))
			else $error("maintenance line wrong");
		// a single fault drives its own line, shown here for the converter fault
		a_fault_line: assert property (@(posedge core_clk_in) disable iff (rst_in)
			r.sel[g] == SDO_ST_CONV && !r.pol[g]
			|=> dout_out[g] == $past(fault_flags_in[SDO_F_CONV]))
			else $error("converter fault line wrong");
		// codes past the end of the list name no state, so the line stays inactive
		a_code_unused: assert property (@(posedge core_clk_in) disable iff (rst_in)
			r.sel[g] > SDO_ST_OVR
			|=> dout_out[g] == $past(r.pol[g]))
			else $error("unused selector code drove a line");
	end
endmodule
`default_nettype wire

// [sdo_logger.sv]
/*
 * Far-side model: external logger that samples the eight discrete status lines.
 * Assumes the lines are settled levels, sampled on the one system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sdo_logger (
	input wire logic core_clk_in, // sampling clock
	input wire logic rst_in, // async reset, active high
	input wire logic [7:0] lines_in, // discrete lines from the mapper
	output logic [7:0] seen_out // last sampled pattern
);
	// =====================================================================
	// sampler
	// one edge of sampling delay, as real equipment adds
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			seen_out <= 8'h00;
		end else begin
			seen_out <= lines_in;
		end
	end
endmodule
`default_nettype wire

// [test_status_digital_output_mapper.sv]
/*
 * Self-checking bench of the status output mapper: register bus, idle and
 * running patterns, state selectors, polarity, over-range and interrupt.
 * Assumes sdo_pkg, sdo_range_if, sdo_range_track, sdo_mapper and sdo_logger.
 */
`timescale 1ns/1ps
`default_nettype none
module test_status_digital_output_mapper;
	import sdo_pkg::*;
	logic core_clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, running = 1'b0;
	logic bg = 1'b0, span = 1'b0, zero = 1'b0, maint = 1'b0, ack, irq;
	logic [7:0] adr = 8'h00, dout, seen;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, tmp;
	logic [SDO_NUM_FAULT-1:0] flags = '0;
	logic [SDO_RD_W-1:0] reading = 16'h0000;
	int fail_count = 0, n_compared = 0;
	// =====================================================================
	// clock, design and far side
	always #5 core_clk = ~core_clk;
	sdo_mapper sdo_mapper_inst (.core_clk_in(core_clk), .rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .running_in(running), .fault_flags_in(flags), .background_in(bg),
		.span_in(span), .zero_in(zero), .maintenance_in(maint), .analog_reading_in(reading),
		.dout_out(dout), .irq_out(irq));
	sdo_logger sdo_logger_inst (.core_clk_in(core_clk), .rst_in(rst), .lines_in(dout), .seen_out(seen));
	// =====================================================================
	// helpers
	task automatic bad(input string msg);
		fail_count++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask
	// one classic cycle; waits for ack, takes data at that edge only
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) bad("no acknowledge");
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, tmp);
	endtask
	// the over-range path needs two edges, the logger one more
	task automatic settle();
		repeat (4) @(posedge core_clk);
	endtask
	task automatic chk_bus(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string msg);
		wb(1'b0, a, 32'h0, tmp);
		n_compared++;
		if ((tmp & m) !== exp) bad(msg);
	endtask
	task automatic chk_line(input logic [7:0] exp, input string msg);
		settle();
		n_compared++;
		if (seen !== exp) bad(msg);
	endtask
	task automatic chk_irq(input logic exp, input string msg);
		settle();
		n_compared++;
		if (irq !== exp) bad(msg);
	endtask
	// drives the instrument condition behind one selector code
	task automatic cause(input int code, input logic v);
		if (code <= 9) flags[code-1] <= v;
		else if (code == 10) bg <= v;
		else if (code == 11) span <= v;
		else if (code == 12) zero <= v;
		else if (code <= 14) flags[SDO_F_DILUENT] <= v;
		else if (code == 15) maint <= v;
		else reading <= v ? 16'h0064 : 16'h0000;
	endtask
	// =====================================================================
	// scenarios
	task automatic t_reset();
		chk_line(8'h00, "lines not inactive after reset");
		chk_bus(SDO_ADR_CTRL, 32'hFFFF_FFFF, 32'h0, "ctrl reset");
		chk_bus(SDO_ADR_SEL_LO, 32'hFFFF_FFFF, 32'h0, "selectors not disabled");
		chk_bus(SDO_ADR_RANGE, 32'hFFFF_FFFF, {16'h0, SDO_RST_RANGE}, "range reset");
		chk_bus(8'h3C, 32'hFFFF_FFFF, 32'h0, "unmapped read");
		$display("test reset done");
	endtask
	task automatic t_patterns();
		wr(SDO_ADR_IDLE, 32'hA5);
		wr(SDO_ADR_POINT, 32'h10);
		wr(SDO_ADR_SEQ, 32'h02);
		wr(SDO_ADR_ALARM, 32'h40);
		chk_line(8'hA5, "idle pattern");
		running <= 1'b1;
		chk_line(8'hF7, "running OR");
		chk_bus(SDO_ADR_RSV, 32'hFF, 32'h40, "reserved view");
		running <= 1'b0;
		chk_line(8'hA5, "back to idle");
		$display("test patterns done");
	endtask
	task automatic t_states();
		wr(SDO_ADR_CTRL, 32'h1);
		wr(SDO_ADR_RANGE, 32'h64);
		wr(SDO_ADR_IDLE, 32'hFF);
		wr(SDO_ADR_POINT, 32'hFF);
		running <= 1'b1;
		for (int c = 1; c <= 16; c++) begin
			wr(SDO_ADR_SEL_LO, 32'(c) << 24);
			chk_line(8'hF7, "masks leak into assigned line");
			cause(c, 1'b1);
			chk_line(8'hFF, "state not driving line");
			cause(c, 1'b0);
			chk_line(8'hF7, "line outlives state");
		end
		wr(SDO_ADR_SEL_LO, 32'h0);
		running <= 1'b0;
		wr(SDO_ADR_IDLE, 32'h0);
		// code 13 shares its flag with code 14, which is driven once
		for (int c = 1; c <= 16; c++) if (c != 13) cause(c, 1'b1);
		chk_line(8'h00, "disabled selector asserted");
		for (int c = 1; c <= 16; c++) if (c != 13) cause(c, 1'b0);
		$display("test states done");
	endtask
	task automatic t_polarity();
		wr(SDO_ADR_POL, 32'hFF);
		chk_line(8'hFF, "active low idle level");
		wr(SDO_ADR_IDLE, 32'h0F);
		chk_line(8'hF0, "active low asserted");
		wr(SDO_ADR_POL, 32'h0);
		wr(SDO_ADR_IDLE, 32'h0);
		$display("test polarity done");
	endtask
	// upper selectors, active low span, zero, system fault, over-range and an unused code
	task automatic t_selectors();
		wr(SDO_ADR_SEL_LO, 32'h000C_001F);
		wr(SDO_ADR_SEL_HI, 32'h100D_000B);
		wr(SDO_ADR_POL, 32'h10);
		chk_line(8'h10, "active low span line idle");
		chk_bus(SDO_ADR_SEL_HI, 32'hFFFF_FFFF, 32'h100D_000B, "upper selectors");
		zero <= 1'b1;
		span <= 1'b1;
		chk_line(8'h04, "zero and span lines");
		chk_bus(SDO_ADR_STATE, 32'hFFFF_FFFF, 32'h0000_1800, "state vector");
		zero <= 1'b0;
		span <= 1'b0;
		flags[SDO_F_CONV] <= 1'b1;
		reading <= 16'h0064;
		chk_line(8'hD0, "fault and over-range lines");
		chk_bus(SDO_ADR_OUT, 32'hFF, 32'hD0, "output view");
		flags[SDO_F_CONV] <= 1'b0;
		reading <= 16'h0000;
		chk_line(8'h10, "lines outlive states");
		wr(SDO_ADR_SEL_LO, 32'h0);
		wr(SDO_ADR_SEL_HI, 32'h0);
		wr(SDO_ADR_POL, 32'h0);
		$display("test selectors done");
	endtask
	task automatic t_overrange();
		wr(SDO_ADR_ISTS, 32'h7);
		wr(SDO_ADR_IMASK, 32'h6);
		reading <= 16'd89;
		chk_irq(1'b0, "entered below 90 percent");
		reading <= 16'd90;
		settle();
		chk_bus(SDO_ADR_ISTS, 32'h6, 32'h2, "no entry at 90 percent");
		wr(SDO_ADR_ISTS, 32'h7);
		reading <= 16'd81;
		chk_irq(1'b0, "left above 80 percent");
		reading <= 16'd80;
		settle();
		chk_bus(SDO_ADR_ISTS, 32'h6, 32'h4, "no exit at 80 percent");
		chk_irq(1'b1, "irq for exit");
		reading <= 16'd0;
		$display("test over-range done");
	endtask
	task automatic t_irq();
		wr(SDO_ADR_ISTS, 32'h7);
		wr(SDO_ADR_IMASK, 32'h1);
		chk_irq(1'b0, "irq without event");
		flags[SDO_F_LAMP] <= 1'b1;
		chk_irq(1'b1, "system fault irq");
		wr(SDO_ADR_ISTS, 32'h1);
		chk_irq(1'b0, "status not cleared");
		wr(SDO_ADR_IMASK, 32'h0);
		flags[SDO_F_LAMP] <= 1'b0;
		settle();
		flags[SDO_F_LAMP] <= 1'b1;
		chk_bus(SDO_ADR_ISTS, 32'h1, 32'h1, "status not sticky");
		chk_irq(1'b0, "masked irq");
		flags[SDO_F_LAMP] <= 1'b0;
		$display("test interrupt done");
	endtask
	// =====================================================================
	// run control
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_patterns();
		t_states();
		t_polarity();
		t_selectors();
		t_overrange();
		t_irq();
		end_of_test();
	end
	// whole run is a few hundred cycles; this is ample margin
	initial begin
		#500000;
		bad("timeout");
		end_of_test();
	end
endmodule
`default_nettype wire
